// ===== common/gde_pkg.sv
// Package for the graphics drawing parameter bank: register map, field
// layouts, reset values, operation codes and the carrier structs.
// Assumes a 32-bit register port and 24-bit maximum pixel depth.
package gde_pkg;

  localparam int GDE_AW = 12;
  localparam int GDE_DW = 32;
  localparam int GDE_PW = 24;
  localparam int GDE_CW = 11;

  // Register byte offsets.
  localparam logic [11:0] GDE_OFF_BLIT_HEIGHT = 12'h004;
  localparam logic [11:0] GDE_OFF_BEGIN_X = 12'h008;
  localparam logic [11:0] GDE_OFF_BEGIN_Y = 12'h00c;
  localparam logic [11:0] GDE_OFF_TARGET_X = 12'h010;
  localparam logic [11:0] GDE_OFF_TARGET_Y = 12'h014;
  localparam logic [11:0] GDE_OFF_THICKNESS = 12'h018;
  localparam logic [11:0] GDE_OFF_PATTERN = 12'h01c;
  localparam logic [11:0] GDE_OFF_COLOUR = 12'h020;
  localparam logic [11:0] GDE_OFF_RASTER_OP = 12'h024;
  localparam logic [11:0] GDE_OFF_GRAPHICS_OP = 12'h028;
  localparam logic [11:0] GDE_OFF_CLIP_CTRL = 12'h040;
  localparam logic [11:0] GDE_OFF_STATUS = 12'h054;
  localparam logic [11:0] GDE_OFF_DEPTH = 12'h070;

  // Writable bit masks; bits outside a mask are reserved and read zero.
  localparam logic [31:0] GDE_MASK_HEIGHT = 32'h0000_07ff;
  localparam logic [31:0] GDE_MASK_COORD = 32'hffff_ffff;
  localparam logic [31:0] GDE_MASK_THICKNESS = 32'h0000_000f;
  localparam logic [31:0] GDE_MASK_PATTERN = 32'h0000_ffff;
  localparam logic [31:0] GDE_MASK_COLOUR = 32'h00ff_ffff;
  localparam logic [31:0] GDE_MASK_RASTER_OP = 32'h0000_000f;
  localparam logic [31:0] GDE_MASK_GRAPHICS_OP = 32'h0000_00ff;
  localparam logic [31:0] GDE_MASK_CLIP = 32'h0000_0001;
  localparam logic [31:0] GDE_MASK_DEPTH = 32'h0000_0007;
  localparam logic [31:0] GDE_REG_RESET = 32'h0000_0000;

  // Field positions.
  localparam int GDE_GOR_CODE_LSB = 4;
  localparam int GDE_GOR_PAT1D_BIT = 0;
  localparam int GDE_CMD_SHIFT = 8;
  localparam int GDE_STAT_BUSY_BIT = 0;
  localparam int GDE_STAT_COUNT_LSB = 16;

  // Graphics operation codes.
  localparam logic [3:0] GDE_GOC_NOP = 4'h0;
  localparam logic [3:0] GDE_GOC_LINE = 4'hd;
  localparam logic [3:0] GDE_GOC_BLIT = 4'hb;
  localparam logic [3:0] GDE_GOC_FILL = 4'hf;

  // Raster operation codes.
  typedef enum logic [3:0] {
    GDE_ROP_MOV = 4'h0,
    GDE_ROP_OR = 4'h1,
    GDE_ROP_AND = 4'h2,
    GDE_ROP_XOR = 4'h3,
    GDE_ROP_NOT = 4'h4,
    GDE_ROP_NOR = 4'h5,
    GDE_ROP_NAND = 4'h6,
    GDE_ROP_XNOR = 4'h7
  } gde_rop_t;

  // Pixel depth codes held in the depth register.
  localparam logic [2:0] GDE_BPP_1 = 3'h0;
  localparam logic [2:0] GDE_BPP_2 = 3'h1;
  localparam logic [2:0] GDE_BPP_4 = 3'h2;
  localparam logic [2:0] GDE_BPP_8 = 3'h3;
  localparam logic [2:0] GDE_BPP_16 = 3'h4;
  localparam logic [2:0] GDE_BPP_24 = 3'h5;

  // Drawing parameters handed to the engine.
  typedef struct packed {
    logic [15:0] cmd_code;
    logic [3:0] op_code;
    logic clip_mode;
    logic [31:0] begin_x;
    logic [31:0] begin_y;
    logic [31:0] target_x;
    logic [31:0] target_y;
    logic [10:0] blit_height;
    logic [3:0] line_thickness;
    logic [23:0] colour;
  } gde_params_t;

  // One pixel operation requested by the engine.
  typedef struct packed {
    logic [10:0] x;
    logic [10:0] y;
    logic [23:0] src;
    logic [23:0] dst;
  } gde_pixel_req_t;

  // Result of one pixel operation.
  typedef struct packed {
    logic write;
    logic [23:0] data;
  } gde_pixel_res_t;

endpackage

// ===== design/gde_raster_alu.sv
// Raster logic unit: combines a source value with the destination pixel.
// Assumes the caller registers the result and supplies a depth mask.
`timescale 1ns/10ps
`default_nettype none
module gde_raster_alu
  import gde_pkg::*;
#(
  parameter int WIDTH = 24
) (
  input wire logic [3:0] rop,
  input wire logic [WIDTH-1:0] src,
  input wire logic [WIDTH-1:0] dst,
  input wire logic [WIDTH-1:0] mask,
  output logic [WIDTH-1:0] result
);

  logic [WIDTH-1:0] raw;

  always_comb begin
    case (gde_rop_t'(rop))
      GDE_ROP_MOV: raw = src;
      GDE_ROP_OR: raw = src | dst;
      GDE_ROP_AND: raw = src & dst;
      GDE_ROP_XOR: raw = src ^ dst;
      GDE_ROP_NOT: raw = ~src;
      GDE_ROP_NOR: raw = ~(src | dst);
      GDE_ROP_NAND: raw = ~(src & dst);
      GDE_ROP_XNOR: raw = ~(src ^ dst);
      default: raw = src;
    endcase
    result = raw & mask;
  end

endmodule // gde_raster_alu
`default_nettype wire

// ===== design/gde_param_regs.sv
// Drawing parameter bank of the graphics engine with its pixel stage.
// Assumes a same-clock register port and a drawing engine that requests
// pixel operations one at a time and reports the end of each operation.
//
// The plain strobed port and the register addresses were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module gde_param_regs
  import gde_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [GDE_AW-1:0] reg_addr,
  input wire logic [GDE_DW-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [GDE_DW-1:0] reg_rdata,
  output logic draw_start,
  output gde_params_t draw_params,
  input wire logic draw_done,
  input wire logic pix_req,
  input wire gde_pixel_req_t pix_in,
  output logic pix_ack,
  output gde_pixel_res_t pix_out
);

  typedef enum logic [1:0] {
    GDE_ST_IDLE = 2'b00,
    GDE_ST_ACTIVE = 2'b01,
    GDE_ST_FINISH = 2'b11
  } gde_state_t;

  // Register storage.
  logic [31:0] height_q, height_d;
  logic [31:0] bx_q, bx_d;
  logic [31:0] by_q, by_d;
  logic [31:0] tx_q, tx_d;
  logic [31:0] ty_q, ty_d;
  logic [31:0] thick_q, thick_d;
  logic [31:0] pat_q, pat_d;
  logic [31:0] colour_q, colour_d;
  logic [31:0] rop_q, rop_d;
  logic [31:0] gop_q, gop_d;
  logic [31:0] clip_q, clip_d;
  logic [31:0] depth_q, depth_d;
  logic [31:0] rdata_q, rdata_d;

  // Operation state.
  gde_state_t state_q, state_d;
  logic start_q, start_d;
  logic [COUNT_W-1:0] count_q, count_d;
  logic [15:0] pat_work_q, pat_work_d;
  logic pat_1d_q, pat_1d_d;
  gde_params_t params_q, params_d;

  // Pixel stage.
  logic ack_q, ack_d;
  gde_pixel_res_t res_q, res_d;

  logic [3:0] op_code;
  logic line_op;
  logic clipped;
  logic [23:0] depth_mask;
  logic [23:0] colour_px;
  logic [23:0] alu_src;
  logic [23:0] alu_result;
  logic pat_bit_2d;
  logic pat_bit;
  logic patterned;
  logic blit_op;
  logic fill_op;
  logic [31:0] status_word;

  // Operation decode from the stored operation register.
  assign op_code = gop_q[GDE_GOR_CODE_LSB +: 4];
  assign line_op = (op_code == GDE_GOC_LINE);
  assign blit_op = (op_code == GDE_GOC_BLIT);
  assign fill_op = (op_code == GDE_GOC_FILL);
  assign clipped = line_op && clip_q[0];

  // Depth mask and colour pick by pixel depth.
  always_comb begin
    depth_mask = 24'h00_0000;
    colour_px = 24'h00_0000;
    case (depth_q[2:0])
      GDE_BPP_1: begin
        depth_mask = 24'h00_0001;
        colour_px = {23'h00_0000, colour_q[3]};
      end
      GDE_BPP_2: begin
        depth_mask = 24'h00_0003;
        colour_px = {22'h00_0000, colour_q[3:2]};
      end
      GDE_BPP_4: begin
        depth_mask = 24'h00_000f;
        colour_px = {20'h0_0000, colour_q[3:0]};
      end
      GDE_BPP_8: begin
        depth_mask = 24'h00_00ff;
        colour_px = {16'h0000, colour_q[7:0]};
      end
      GDE_BPP_16: begin
        depth_mask = 24'h00_ffff;
        colour_px = {8'h00, colour_q[15:0]};
      end
      GDE_BPP_24: begin
        depth_mask = 24'hff_ffff;
        colour_px = colour_q[23:0];
      end
      default: begin
        depth_mask = 24'hff_ffff;
        colour_px = colour_q[23:0];
      end
    endcase
  end

  // Pattern bit: 2D selects by low X and Y bits, rows counted from the top.
  always_comb begin
    pat_bit_2d = pat_q[{~pix_in.y[1:0], pix_in.x[1:0]}];
    pat_bit = pat_1d_q ? pat_work_q[0] : pat_bit_2d;
    patterned = line_op || fill_op;
    alu_src = blit_op ? pix_in.src : colour_px;
  end

  gde_raster_alu #(
    .WIDTH(GDE_PW)
  ) u_alu (
    .rop(rop_q[3:0]),
    .src(alu_src),
    .dst(pix_in.dst),
    .mask(depth_mask),
    .result(alu_result)
  );

  // Status word: busy flag and pixel count of the current or last operation.
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[GDE_STAT_BUSY_BIT] = (state_q != GDE_ST_IDLE);
    status_word[GDE_STAT_COUNT_LSB +: COUNT_W] = count_q;
  end

  // Register port: writes and reads; the sequencer below starts operations.
  always_comb begin
    height_d = height_q;
    bx_d = bx_q;
    by_d = by_q;
    tx_d = tx_q;
    ty_d = ty_q;
    thick_d = thick_q;
    pat_d = pat_q;
    colour_d = colour_q;
    rop_d = rop_q;
    gop_d = gop_q;
    clip_d = clip_q;
    depth_d = depth_q;
    rdata_d = 32'h0000_0000;
    if (reg_write) begin
      case (reg_addr)
        GDE_OFF_BLIT_HEIGHT: height_d = reg_wdata & GDE_MASK_HEIGHT;
        GDE_OFF_BEGIN_X: bx_d = reg_wdata & GDE_MASK_COORD;
        GDE_OFF_BEGIN_Y: by_d = reg_wdata & GDE_MASK_COORD;
        GDE_OFF_TARGET_X: tx_d = reg_wdata & GDE_MASK_COORD;
        GDE_OFF_TARGET_Y: ty_d = reg_wdata & GDE_MASK_COORD;
        GDE_OFF_THICKNESS: thick_d = reg_wdata & GDE_MASK_THICKNESS;
        GDE_OFF_PATTERN: pat_d = reg_wdata & GDE_MASK_PATTERN;
        GDE_OFF_COLOUR: colour_d = reg_wdata & GDE_MASK_COLOUR;
        GDE_OFF_RASTER_OP: rop_d = reg_wdata & GDE_MASK_RASTER_OP;
        GDE_OFF_GRAPHICS_OP: gop_d = reg_wdata & GDE_MASK_GRAPHICS_OP;
        GDE_OFF_CLIP_CTRL: clip_d = reg_wdata & GDE_MASK_CLIP;
        GDE_OFF_DEPTH: depth_d = reg_wdata & GDE_MASK_DEPTH;
        default: ;
      endcase
    end
    if (reg_read) begin
      case (reg_addr)
        GDE_OFF_BLIT_HEIGHT: rdata_d = height_q;
        GDE_OFF_BEGIN_X: rdata_d = bx_q;
        GDE_OFF_BEGIN_Y: rdata_d = by_q;
        GDE_OFF_TARGET_X: rdata_d = tx_q;
        GDE_OFF_TARGET_Y: rdata_d = ty_q;
        GDE_OFF_THICKNESS: rdata_d = thick_q;
        GDE_OFF_PATTERN: rdata_d = pat_q;
        GDE_OFF_COLOUR: rdata_d = colour_q;
        GDE_OFF_RASTER_OP: rdata_d = rop_q;
        GDE_OFF_GRAPHICS_OP: rdata_d = gop_q;
        GDE_OFF_CLIP_CTRL: rdata_d = clip_q;
        GDE_OFF_DEPTH: rdata_d = depth_q;
        GDE_OFF_STATUS: rdata_d = status_word;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end

  // Operation sequencer and parameter copy, re-registered every cycle.
  always_comb begin
    state_d = state_q;
    start_d = 1'b0;
    count_d = count_q;
    pat_work_d = pat_work_q;
    pat_1d_d = pat_1d_q;
    params_d = params_q;
    params_d.cmd_code = {gop_q[7:0], 8'h00} | {8'h00, rop_q[7:0]};
    params_d.op_code = op_code;
    params_d.clip_mode = clipped;
    params_d.begin_x = clipped ? bx_q : {21'h00_0000, bx_q[10:0]};
    params_d.begin_y = clipped ? by_q : {21'h00_0000, by_q[10:0]};
    params_d.target_x = clipped ? tx_q : {21'h00_0000, tx_q[10:0]};
    params_d.target_y = clipped ? ty_q : {21'h00_0000, ty_q[10:0]};
    params_d.blit_height = height_q[10:0];
    params_d.line_thickness = thick_q[3:0];
    params_d.colour = colour_px;
    case (state_q)
      GDE_ST_IDLE: begin
        if (reg_write && reg_addr == GDE_OFF_GRAPHICS_OP &&
            reg_wdata[GDE_GOR_CODE_LSB +: 4] != GDE_GOC_NOP) begin
          state_d = GDE_ST_ACTIVE;
          start_d = 1'b1;
          count_d = '0;
          pat_work_d = pat_q[15:0];
          pat_1d_d = reg_wdata[GDE_GOR_PAT1D_BIT];
        end
      end
      GDE_ST_ACTIVE: begin
        if (draw_done) begin
          state_d = GDE_ST_FINISH;
        end
      end
      GDE_ST_FINISH: begin
        state_d = GDE_ST_IDLE;
      end
      default: state_d = GDE_ST_IDLE;
    endcase
    if (pix_req && state_q == GDE_ST_ACTIVE) begin
      count_d = count_q + COUNT_W'(1);
      if (pat_1d_q && patterned) begin
        pat_work_d = {pat_work_q[0], pat_work_q[15:1]};
      end
    end
  end

  // Pixel stage: pattern gating and raster result, one cycle later.
  always_comb begin
    ack_d = pix_req;
    res_d = res_q;
    if (pix_req) begin
      res_d.write = patterned ? pat_bit : 1'b1;
      res_d.data = alu_result;
    end
  end

  // Register bank storage, cleared by reset.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      height_q <= GDE_REG_RESET;
      bx_q <= GDE_REG_RESET;
      by_q <= GDE_REG_RESET;
      tx_q <= GDE_REG_RESET;
      ty_q <= GDE_REG_RESET;
      thick_q <= GDE_REG_RESET;
      pat_q <= GDE_REG_RESET;
      colour_q <= GDE_REG_RESET;
      rop_q <= GDE_REG_RESET;
      gop_q <= GDE_REG_RESET;
      clip_q <= GDE_REG_RESET;
      depth_q <= GDE_REG_RESET;
      rdata_q <= GDE_REG_RESET;
    end else begin
      height_q <= height_d;
      bx_q <= bx_d;
      by_q <= by_d;
      tx_q <= tx_d;
      ty_q <= ty_d;
      thick_q <= thick_d;
      pat_q <= pat_d;
      colour_q <= colour_d;
      rop_q <= rop_d;
      gop_q <= gop_d;
      clip_q <= clip_d;
      depth_q <= depth_d;
      rdata_q <= rdata_d;
    end
  end

  // Sequencer state and parameter copy, re-registered every cycle.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= GDE_ST_IDLE;
      start_q <= 1'b0;
      count_q <= '0;
      pat_work_q <= 16'h0000;
      pat_1d_q <= 1'b0;
      params_q <= '0;
    end else begin
      state_q <= state_d;
      start_q <= start_d;
      count_q <= count_d;
      pat_work_q <= pat_work_d;
      pat_1d_q <= pat_1d_d;
      params_q <= params_d;
    end
  end

  // Pixel stage answer registers.
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      ack_q <= 1'b0;
      res_q <= '0;
    end else begin
      ack_q <= ack_d;
      res_q <= res_d;
    end
  end

  // Every output comes straight from a flip-flop.
  assign reg_rdata = rdata_q;
  assign draw_start = start_q;
  assign draw_params = params_q;
  assign pix_ack = ack_q;
  assign pix_out = res_q;

endmodule // gde_param_regs
`default_nettype wire

// ===== verification/gde_param_regs_monitor.sv
// Concurrent checks on the ports of the drawing parameter bank.
// Assumes the bench holds every strobe low while reset is high.
`timescale 1ns/10ps
`default_nettype none
module gde_param_regs_monitor
  import gde_pkg::*;
#(
  parameter int COUNT_W = 16
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic [GDE_AW-1:0] reg_addr,
  input wire logic [GDE_DW-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [GDE_DW-1:0] reg_rdata,
  input wire logic draw_start,
  input wire gde_params_t draw_params,
  input wire logic draw_done,
  input wire logic pix_req,
  input wire gde_pixel_req_t pix_in,
  input wire logic pix_ack,
  input wire gde_pixel_res_t pix_out
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (reset);
  rdata_idle_a: assert property (!$past(reg_read) |-> reg_rdata == '0)
    else $error("read data not zero outside a read answer");
  ack_follow_a: assert property (pix_ack == $past(pix_req))
    else $error("pixel answer not one cycle after request");
  start_cause_a: assert property (draw_start |-> $past(reg_write) &&
    $past(reg_addr) == GDE_OFF_GRAPHICS_OP && $past(reg_wdata[7:4]) != 4'h0)
    else $error("start without operation write");
  start_single_a: assert property (draw_start |=> !draw_start)
    else $error("start longer than one cycle");
  height_load_a: assert property ($past(reg_write && reg_addr == GDE_OFF_BLIT_HEIGHT, 2)
    |-> draw_params.blit_height == $past(reg_wdata[10:0], 2))
    else $error("blit height not applied");
  width_load_a: assert property ($past(reg_write && reg_addr == GDE_OFF_THICKNESS, 2)
    |-> draw_params.line_thickness == $past(reg_wdata[3:0], 2))
    else $error("line width not applied");
  cmd_high_a: assert property ($past(reg_write && reg_addr == GDE_OFF_GRAPHICS_OP, 2)
    |-> draw_params.cmd_code[15:8] == $past(reg_wdata[7:0], 2) &&
    draw_params.op_code == $past(reg_wdata[7:4], 2))
    else $error("operation code not placed in command");
  cmd_low_a: assert property ($past(reg_write && reg_addr == GDE_OFF_RASTER_OP, 2)
    |-> draw_params.cmd_code[7:0] == {4'h0, $past(reg_wdata[3:0], 2)})
    else $error("raster code not placed in command");
  coord_narrow_a: assert property (!draw_params.clip_mode |->
    draw_params.begin_x[31:11] == '0 && draw_params.target_y[31:11] == '0)
    else $error("unclipped coordinate wider than 11 bits");
  clip_line_a: assert property (draw_params.clip_mode |-> draw_params.op_code == GDE_GOC_LINE)
    else $error("clip mode outside a line draw");
  cover property (draw_start);
  cover property (draw_params.clip_mode);
  cover property (pix_ack && !pix_out.write);
endmodule // gde_param_regs_monitor
`default_nettype wire

// ===== verification/test_gde_param_regs.sv
// Self-checking bench for the drawing parameter bank, random with corner cases.
// Assumes the package, design and checker files are compiled before this one.
`timescale 1ns/10ps
`default_nettype none
module test_gde_param_regs;
  import gde_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic [11:0] reg_addr = '0;
  logic [31:0] reg_wdata = '0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [31:0] reg_rdata;
  logic draw_start;
  gde_params_t draw_params;
  logic draw_done = 1'b0;
  logic pix_req = 1'b0;
  gde_pixel_req_t pix_in = '0;
  logic pix_ack;
  gde_pixel_res_t pix_out;
  int fails = 0;
  int n_checks = 0;
  int cyc = 0;
  int seed = 32'hfb3b6640;
  logic [11:0] offs [11] = '{GDE_OFF_BLIT_HEIGHT, GDE_OFF_BEGIN_X, GDE_OFF_BEGIN_Y,
    GDE_OFF_TARGET_X, GDE_OFF_TARGET_Y, GDE_OFF_THICKNESS, GDE_OFF_PATTERN, GDE_OFF_COLOUR,
    GDE_OFF_RASTER_OP, GDE_OFF_CLIP_CTRL, GDE_OFF_DEPTH};
  logic [31:0] masks [11] = '{32'h7ff, 32'hffffffff, 32'hffffffff, 32'hffffffff,
    32'hffffffff, 32'hf, 32'hffff, 32'hffffff, 32'hf, 32'h1, 32'h7};

  gde_param_regs #(.COUNT_W(16)) gde_param_regs_i (.clk_sys(clk_sys), .reset(reset),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .draw_start(draw_start), .draw_params(draw_params),
    .draw_done(draw_done), .pix_req(pix_req), .pix_in(pix_in), .pix_ack(pix_ack),
    .pix_out(pix_out));

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic tally_and_finish;
    $display("checks %0d fails %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fails++;
      tally_and_finish;
    end
  end

  task automatic chk(input logic [127:0] g, input logic [127:0] e, input string m);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, g, e);
    end
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk_sys);
    reg_write <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk_sys);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask

  task automatic px(input logic [10:0] x, input logic [10:0] y, input logic [23:0] s,
                    input logic [23:0] dd);
    @(posedge clk_sys);
    pix_in <= '{x: x, y: y, src: s, dst: dd};
    pix_req <= 1'b1;
    @(posedge clk_sys);
    pix_req <= 1'b0;
    #1;
    chk(pix_ack, 1'b1, "pixel ack");
  endtask

  task automatic go(input logic [7:0] g, input logic e);
    wr(GDE_OFF_GRAPHICS_OP, {24'h0, g});
    #1;
    chk(draw_start, e, "start");
  endtask

  task automatic fin;
    @(posedge clk_sys);
    draw_done <= 1'b1;
    @(posedge clk_sys);
    draw_done <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  function automatic logic [23:0] rop_f(input int r, input logic [23:0] s,
                                        input logic [23:0] d);
    case (r)
      1: return s | d;
      2: return s & d;
      3: return s ^ d;
      4: return ~s;
      5: return ~(s | d);
      6: return ~(s & d);
      7: return ~(s ^ d);
      default: return s;
    endcase
  endfunction

  function automatic logic [23:0] col_f(input int k, input logic [23:0] c);
    case (k)
      0: return {23'h0, c[3]};
      1: return {22'h0, c[3:2]};
      2: return {20'h0, c[3:0]};
      3: return {16'h0, c[7:0]};
      4: return {8'h0, c[15:0]};
      default: return c;
    endcase
  endfunction

  initial begin
    logic [31:0] d, v;
    logic [15:0] p;
    logic [127:0] cv, e, g;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (offs[i]) begin
      rd(offs[i], d);
      chk(d, 32'h0, "reset value");
      v = $random(seed);
      wr(offs[i], v);
      rd(offs[i], d);
      chk(d, v & masks[i], "readback");
    end
    rd(GDE_OFF_GRAPHICS_OP, d);
    chk(d, 32'h0, "operation reset");
    wr(12'h0fc, 32'hffffffff);
    rd(12'h0fc, d);
    chk(d, 32'h0, "unmapped");
    p = $random(seed);
    wr(GDE_OFF_RASTER_OP, 32'h0);
    wr(GDE_OFF_PATTERN, {16'h0, p});
    go(8'hd4, 1'b1);
    go(8'hd4, 1'b0);
    for (int k = 0; k < 8; k++) begin
      v = $random(seed);
      wr(GDE_OFF_DEPTH, 32'(k));
      wr(GDE_OFF_COLOUR, v);
      px(11'h0, 11'h0, 24'h0, 24'h0);
      chk(pix_out.data, col_f(k, v[23:0]), "colour");
      chk(draw_params.colour, col_f(k, v[23:0]), "param colour");
    end
    for (int k = 0; k < 12; k++) begin
      v = $random(seed);
      px(v[10:0], v[21:11], v[23:0], 24'h0);
      chk(pix_out.write, p[12 - 4 * v[12:11] + v[1:0]], "2d pattern");
    end
    cv = {$random(seed), $random(seed), $random(seed), $random(seed)};
    wr(GDE_OFF_CLIP_CTRL, 32'h1);
    for (int i = 0; i < 4; i++) wr(offs[i + 1], cv[127 - 32 * i -: 32]);
    repeat (2) @(posedge clk_sys);
    #1;
    g = {draw_params.begin_x, draw_params.begin_y, draw_params.target_x, draw_params.target_y};
    chk(g, cv, "clipped coords");
    fin;
    go(8'hd5, 1'b1);
    for (int k = 0; k < 20; k++) begin
      px(11'h0, 11'h0, 24'h0, 24'h0);
      chk(pix_out.write, p[k % 16], "1d pattern");
    end
    rd(GDE_OFF_STATUS, d);
    chk(d, (32'(20) << GDE_STAT_COUNT_LSB) | (32'h1 << GDE_STAT_BUSY_BIT), "busy");
    fin;
    go(8'hb4, 1'b1);
    repeat (2) @(posedge clk_sys);
    #1;
    for (int i = 0; i < 4; i++) e[127 - 32 * i -: 32] = {21'h0, cv[106 - 32 * i -: 11]};
    g = {draw_params.begin_x, draw_params.begin_y, draw_params.target_x, draw_params.target_y};
    chk(g, e, "blit coords");
    for (int r = 0; r < 9; r++) begin
      v = $random(seed);
      d = $random(seed);
      wr(GDE_OFF_RASTER_OP, 32'(r));
      px(11'h0, 11'h0, v[23:0], d[23:0]);
      chk({pix_out.write, pix_out.data}, {1'b1, rop_f(r, v[23:0], d[23:0])}, "raster");
    end
    fin;
    go(8'hf4, 1'b1);
    for (int k = 0; k < 4; k++) begin
      v = $random(seed);
      px(v[10:0], v[21:11], v[23:0], 24'h0);
      chk(pix_out.write, p[12 - 4 * v[12:11] + v[1:0]], "fill pattern");
    end
    fin;
    rd(GDE_OFF_STATUS, d);
    chk(d, 32'(4) << GDE_STAT_COUNT_LSB, "idle status");
    @(posedge clk_sys);
    reset <= 1'b1;
    repeat (2) @(posedge clk_sys);
    reset <= 1'b0;
    foreach (offs[i]) begin
      rd(offs[i], d);
      chk(d, 32'h0, "reset clear");
    end
    tally_and_finish;
  end
endmodule // test_gde_param_regs

bind gde_param_regs gde_param_regs_monitor #(.COUNT_W(COUNT_W)) gde_param_regs_monitor_i (
  .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .draw_start(draw_start),
  .draw_params(draw_params), .draw_done(draw_done), .pix_req(pix_req), .pix_in(pix_in),
  .pix_ack(pix_ack), .pix_out(pix_out));
`default_nettype wire
